// File: rtl/lrs_bank.sv
// Register bank of N entries of W bits with one write port and all contents visible
module lrs_bank
   import lrs_pkg::*;
#(
   parameter int N = 14,
   parameter int W = 4,
   parameter logic [N*W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wr_en,
   input wire logic [3:0] wr_idx,
   input wire logic [W-1:0] wr_data,
   output logic [N*W-1:0] contents
);

   // ****************************************
   // Storage
   // ****************************************
   typedef struct packed {
      logic [N-1:0][W-1:0] mem;
   } lrs_bank_t;

   lrs_bank_t bank_r;
   lrs_bank_t bank_nxt;

   // Refused at elaboration: a 4-bit index cannot reach past sixteen entries
   if (N < 1 || N > 16 || W < 1) begin : g_param_chk
      $error("lrs_bank: N must be 1..16 and W at least 1");
   end

   // Index past the end is dropped rather than wrapping
   always_comb begin
      bank_nxt = bank_r;
      if (wr_en && 32'(wr_idx) < N) begin
         bank_nxt.mem[wr_idx] = wr_data;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bank_r <= INIT;
      end else begin
         bank_r <= bank_nxt;
      end
   end

   assign contents = bank_r;

endmodule

// File: rtl/lrs_pkg.sv
// Types shared by the loop register access sequencer
package lrs_pkg;

   typedef enum logic [2:0] {
      LRS_IDLE,
      LRS_WRITE,
      LRS_RD_WAIT,
      LRS_RD_LOAD,
      LRS_RD_SEND,
      LRS_RD_EOT
   } lrs_state_t;

   typedef struct packed {
      lrs_state_t st;
      logic listen;
      logic talk;
      logic bank_char;
      logic [3:0] ptr;
      logic tx_valid;
      logic tx_eot;
      logic [7:0] tx_data;
      logic ack;
      logic lwr_prev;
      logic [31:0] rdata;
      logic [4:0] loop_addr;
      logic local_mode;
   } lrs_seq_t;

   typedef struct packed {
      logic [3:0] ptr_unused;
   } lrs_dummy_t;

endpackage

// File: rtl/lrs_regs.svh
// Offsets, field positions, codes and reset values of the loop register access sequencer
`ifndef LRS_REGS_SVH
`define LRS_REGS_SVH

// ****************************************
// Avalon byte offsets
// ****************************************
`define LRS_CTRL_OFS 8'h00
`define LRS_STAT_OFS 8'h04
`define LRS_CREG_BASE 8'h40
`define LRS_CHAR_BASE 8'h80
`define LRS_BANK_MASK 8'hc0

// ****************************************
// Field positions
// ****************************************
`define LRS_CTRL_ADDR_LSB 0
`define LRS_CTRL_LOCAL_BIT 8
`define LRS_STAT_LISTEN_BIT 0
`define LRS_STAT_TALK_BIT 1
`define LRS_STAT_BANK_BIT 2
`define LRS_STAT_STATE_LSB 4
`define LRS_STAT_PTR_LSB 8

// ****************************************
// Reset values
// ****************************************
`define LRS_LOOP_ADDR_RST 5'h00
`define LRS_LOCAL_RST 1'b1
`define LRS_BIT_RATE_IDX 7
`define LRS_BIT_RATE_RST 4'he

// ****************************************
// Loop message codes on the decoded message port
// ****************************************
`define LRS_MSG_DATA 4'h0
`define LRS_MSG_LISTEN 4'h1
`define LRS_MSG_TALK 4'h2
`define LRS_MSG_UNLISTEN 4'h3
`define LRS_MSG_UNTALK 4'h4
`define LRS_MSG_DDL 4'h5
`define LRS_MSG_DDT 4'h6
`define LRS_MSG_SEND_DATA 4'h7
`define LRS_MSG_EOT_OK 4'h8

// Device-dependent message numbers selecting a bank
`define LRS_DD_CTRL 8'h00
`define LRS_DD_CHAR 8'h02

// Upper nibble placed above a control value on readback
`define LRS_RB_UPPER 4'h3

`endif

// File: rtl/lrs_seq.sv
// Loop register access sequencer: loop message sequencing, two register banks, Avalon slave
`include "lrs_regs.svh"

module lrs_seq
   import lrs_pkg::*;
#(
   parameter int CTRL_COUNT = 14,
   parameter int CHAR_COUNT = 12
) (
   input wire logic REF_CLK_IN,
   input wire logic RSTN_IN,
   input wire logic MSG_VALID_IN,
   input wire logic [3:0] MSG_KIND_IN,
   input wire logic [7:0] MSG_ARG_IN,
   output logic TX_VALID_OUT,
   output logic TX_EOT_OUT,
   output logic [7:0] TX_DATA_OUT,
   input wire logic TX_READY_IN,
   input wire logic [7:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   output logic LISTENER_OUT,
   output logic TALKER_OUT
);

   // ****************************************
   // Declarations
   // ****************************************
   localparam logic [CTRL_COUNT*4-1:0] CTRL_INIT =
      (CTRL_COUNT*4)'(`LRS_BIT_RATE_RST) << (`LRS_BIT_RATE_IDX * 4);

   lrs_seq_t s_r;
   lrs_seq_t s_nxt;
   logic [CTRL_COUNT*4-1:0] ctrl_bits;
   logic [CHAR_COUNT*8-1:0] char_bits;
   logic [CTRL_COUNT-1:0][3:0] ctrl_arr;
   logic [CHAR_COUNT-1:0][7:0] char_arr;
   logic loop_wr;
   logic [7:0] loop_wr_data;
   logic bus_req;
   logic grant;
   logic bus_wr;
   logic [5:0] bus_idx;
   logic bus_in_ctrl;
   logic bus_in_char;
   logic wr_en_ctrl;
   logic wr_en_char;
   logic [3:0] wr_idx;
   logic [7:0] wr_data;
   logic [3:0] last_idx;
   logic [7:0] cur_val;

   // Refused at elaboration: the 4-bit pointer must step past the last register so extras drop
   if (CTRL_COUNT < 1 || CTRL_COUNT > 15 || CHAR_COUNT < 1 || CHAR_COUNT > 15) begin : g_param_chk
      $error("lrs_seq: bank sizes must be 1..15");
   end

   assign ctrl_arr = ctrl_bits;
   assign char_arr = char_bits;

   // ****************************************
   // Bus decode
   // ****************************************
   // A loop write owns the bank write port; the bus waits that cycle and the next rather than lose it
   assign bus_req = AVS_READ_IN | AVS_WRITE_IN;
   assign grant = s_r.ack & ~loop_wr & ~s_r.lwr_prev;
   assign bus_wr = AVS_WRITE_IN & grant;
   assign bus_idx = AVS_ADDRESS_IN[7:2] & 6'h0f;
   assign bus_in_ctrl = (AVS_ADDRESS_IN & `LRS_BANK_MASK) == `LRS_CREG_BASE
                        && 32'(bus_idx) < CTRL_COUNT;
   assign bus_in_char = (AVS_ADDRESS_IN & `LRS_BANK_MASK) == `LRS_CHAR_BASE
                        && 32'(bus_idx) < CHAR_COUNT;

   // Current register for the sequence and the last valid index of its bank
   assign last_idx = s_r.bank_char ? 4'(CHAR_COUNT - 1) : 4'(CTRL_COUNT - 1);
   assign cur_val = s_r.bank_char ? char_arr[s_r.ptr] : {`LRS_RB_UPPER, ctrl_arr[s_r.ptr]};

   // Loop write: a data byte while listening in a write sequence, local mode only
   assign loop_wr = MSG_VALID_IN && MSG_KIND_IN == `LRS_MSG_DATA && s_r.st == LRS_WRITE
                    && s_r.listen && s_r.local_mode && s_r.ptr <= last_idx;
   assign loop_wr_data = MSG_ARG_IN;

   // Shared write port of both banks
   always_comb begin
      wr_en_ctrl = 1'b0;
      wr_en_char = 1'b0;
      wr_idx = s_r.ptr;
      wr_data = loop_wr_data;
      if (loop_wr) begin
         wr_en_ctrl = ~s_r.bank_char;
         wr_en_char = s_r.bank_char;
      end else if (bus_wr && AVS_BYTEENABLE_IN[0]) begin
         wr_en_ctrl = bus_in_ctrl;
         wr_en_char = bus_in_char;
         wr_idx = bus_idx[3:0];
         wr_data = AVS_WRITEDATA_IN[7:0];
      end
   end

   // ****************************************
   // Register banks
   // ****************************************
   lrs_bank #(
      .N(CTRL_COUNT),
      .W(4),
      .INIT(CTRL_INIT)
   ) u_ctrl_bank (
      .clk(REF_CLK_IN),
      .rstn(RSTN_IN),
      .wr_en(wr_en_ctrl),
      .wr_idx(wr_idx),
      .wr_data(wr_data[3:0]),
      .contents(ctrl_bits)
   );

   lrs_bank #(
      .N(CHAR_COUNT),
      .W(8),
      .INIT('0)
   ) u_char_bank (
      .clk(REF_CLK_IN),
      .rstn(RSTN_IN),
      .wr_en(wr_en_char),
      .wr_idx(wr_idx),
      .wr_data(wr_data),
      .contents(char_bits)
   );

   // ****************************************
   // Sequencer and bus next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.lwr_prev = loop_wr;

      // Loop addressing, acted on in any mode
      if (MSG_VALID_IN) begin
         unique case (MSG_KIND_IN)
            `LRS_MSG_LISTEN: begin
               if (MSG_ARG_IN[4:0] == s_r.loop_addr) begin
                  s_nxt.listen = 1'b1;
               end
            end
            `LRS_MSG_UNLISTEN: begin
               s_nxt.listen = 1'b0;
               if (s_r.st == LRS_WRITE) begin
                  s_nxt.st = LRS_IDLE;
               end
            end
            `LRS_MSG_TALK: begin
               // Another device's talk address removes this one as talker
               s_nxt.talk = MSG_ARG_IN[4:0] == s_r.loop_addr;
               if (MSG_ARG_IN[4:0] != s_r.loop_addr) begin
                  s_nxt.st = LRS_IDLE;
                  s_nxt.tx_valid = 1'b0;
               end
            end
            `LRS_MSG_UNTALK: begin
               s_nxt.talk = 1'b0;
               if (s_r.st != LRS_WRITE) begin
                  s_nxt.st = LRS_IDLE;
                  s_nxt.tx_valid = 1'b0;
               end
            end
            `LRS_MSG_DDL: begin
               if (s_r.listen && s_r.local_mode) begin
                  s_nxt.ptr = 4'h0;
                  s_nxt.tx_valid = 1'b0;
                  if (MSG_ARG_IN == `LRS_DD_CTRL || MSG_ARG_IN == `LRS_DD_CHAR) begin
                     s_nxt.st = LRS_WRITE;
                     s_nxt.bank_char = MSG_ARG_IN == `LRS_DD_CHAR;
                  end else begin
                     s_nxt.st = LRS_IDLE;
                  end
               end
            end
            `LRS_MSG_DDT: begin
               if (s_r.talk && s_r.local_mode) begin
                  s_nxt.ptr = 4'h0;
                  s_nxt.tx_valid = 1'b0;
                  if (MSG_ARG_IN == `LRS_DD_CTRL || MSG_ARG_IN == `LRS_DD_CHAR) begin
                     s_nxt.st = LRS_RD_WAIT;
                     s_nxt.bank_char = MSG_ARG_IN == `LRS_DD_CHAR;
                  end else begin
                     s_nxt.st = LRS_IDLE;
                  end
               end
            end
            `LRS_MSG_SEND_DATA: begin
               if (s_r.st == LRS_RD_WAIT && s_r.talk && s_r.local_mode) begin
                  s_nxt.st = LRS_RD_LOAD;
               end
            end
            `LRS_MSG_EOT_OK: begin
               if (s_r.st == LRS_WRITE) begin
                  s_nxt.st = LRS_IDLE;
               end
            end
            `LRS_MSG_DATA: begin
               if (loop_wr) begin
                  s_nxt.ptr = s_r.ptr + 4'h1;
               end
            end
            default: begin
            end
         endcase
      end

      // Readback: load a value, offer it, step on acceptance, then End-OK
      if (s_nxt.st == s_r.st && s_r.talk) begin
         unique case (s_r.st)
            LRS_RD_LOAD: begin
               s_nxt.tx_data = cur_val;
               s_nxt.tx_eot = 1'b0;
               s_nxt.tx_valid = 1'b1;
               s_nxt.st = LRS_RD_SEND;
            end
            LRS_RD_SEND: begin
               if (TX_READY_IN) begin
                  s_nxt.tx_valid = 1'b0;
                  if (s_r.ptr == last_idx) begin
                     s_nxt.st = LRS_RD_EOT;
                     s_nxt.tx_eot = 1'b1;
                     s_nxt.tx_data = 8'h00;
                     s_nxt.tx_valid = 1'b1;
                  end else begin
                     s_nxt.ptr = s_r.ptr + 4'h1;
                     s_nxt.st = LRS_RD_LOAD;
                  end
               end
            end
            LRS_RD_EOT: begin
               if (TX_READY_IN) begin
                  s_nxt.tx_valid = 1'b0;
                  s_nxt.tx_eot = 1'b0;
                  s_nxt.st = LRS_IDLE;
               end
            end
            default: begin
            end
         endcase
      end

      // Leaving local mode abandons any device-dependent sequence
      if (!s_r.local_mode && s_r.st != LRS_IDLE) begin
         s_nxt.st = LRS_IDLE;
         s_nxt.tx_valid = 1'b0;
         s_nxt.tx_eot = 1'b0;
      end

      // An aborted End-OK offer must not leave the mark standing without valid
      if (!s_nxt.tx_valid) begin
         s_nxt.tx_eot = 1'b0;
      end

      // Bus: waitrequest low one cycle after the request at the earliest
      s_nxt.ack = bus_req & ~grant;
      s_nxt.rdata = 32'h0;
      if (AVS_ADDRESS_IN == `LRS_CTRL_OFS) begin
         s_nxt.rdata[`LRS_CTRL_ADDR_LSB +: 5] = s_r.loop_addr;
         s_nxt.rdata[`LRS_CTRL_LOCAL_BIT] = s_r.local_mode;
      end else if (AVS_ADDRESS_IN == `LRS_STAT_OFS) begin
         s_nxt.rdata[`LRS_STAT_LISTEN_BIT] = s_r.listen;
         s_nxt.rdata[`LRS_STAT_TALK_BIT] = s_r.talk;
         s_nxt.rdata[`LRS_STAT_BANK_BIT] = s_r.bank_char;
         s_nxt.rdata[`LRS_STAT_STATE_LSB +: 3] = s_r.st;
         s_nxt.rdata[`LRS_STAT_PTR_LSB +: 4] = s_r.ptr;
      end else if (bus_in_ctrl) begin
         s_nxt.rdata[3:0] = ctrl_arr[bus_idx[3:0]];
      end else if (bus_in_char) begin
         s_nxt.rdata[7:0] = char_arr[bus_idx[3:0]];
      end
      if (bus_wr && AVS_ADDRESS_IN == `LRS_CTRL_OFS) begin
         if (AVS_BYTEENABLE_IN[0]) begin
            s_nxt.loop_addr = AVS_WRITEDATA_IN[`LRS_CTRL_ADDR_LSB +: 5];
         end
         if (AVS_BYTEENABLE_IN[1]) begin
            s_nxt.local_mode = AVS_WRITEDATA_IN[`LRS_CTRL_LOCAL_BIT];
         end
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         s_r <= '{st: LRS_IDLE, listen: 1'b0, talk: 1'b0, bank_char: 1'b0, ptr: 4'h0,
                  tx_valid: 1'b0, tx_eot: 1'b0, tx_data: 8'h00, ack: 1'b0, lwr_prev: 1'b0,
                  rdata: 32'h0, loop_addr: `LRS_LOOP_ADDR_RST, local_mode: `LRS_LOCAL_RST};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs
   assign TX_VALID_OUT = s_r.tx_valid;
   assign TX_EOT_OUT = s_r.tx_eot;
   assign TX_DATA_OUT = s_r.tx_data;
   assign AVS_READDATA_OUT = s_r.rdata;
   assign AVS_WAITREQUEST_OUT = bus_req & ~grant;
   assign LISTENER_OUT = s_r.listen;
   assign TALKER_OUT = s_r.talk;

endmodule

// File: test/lrs_ctl_model.sv
// Loop controller model: sends decoded loop messages and accepts bytes sourced by the device
`include "lrs_regs.svh"
module lrs_ctl_model (
   input wire logic clk,
   output logic msg_valid,
   output logic [3:0] msg_kind,
   output logic [7:0] msg_arg,
   output logic tx_ready,
   input wire logic tx_valid,
   input wire logic tx_eot,
   input wire logic [7:0] tx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rx_q[$];
   logic got_eot;
   initial begin
      msg_valid = 1'b0;
      msg_kind = 4'hf;
      msg_arg = 8'h00;
      tx_ready = 1'b0;
      got_eot = 1'b0;
   end
   // One message per call; released lines are inverted so a stale value is never trusted
   task automatic send(input logic [3:0] k, input logic [7:0] a);
      @(posedge clk);
      msg_valid <= 1'b1;
      msg_kind <= k;
      msg_arg <= a;
      @(posedge clk);
      msg_valid <= 1'b0;
      msg_kind <= ~k;
      msg_arg <= ~a;
   endtask
   // Accepts up to lim items in cyc cycles; slow mode stalls at random to test holding
   task automatic collect(input bit slow, input int lim, input int cyc);
      int n;
      n = 0;
      got_eot = 1'b0;
      rx_q = {};
      while (n < cyc && !got_eot && rx_q.size() < lim) begin
         tx_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
         @(posedge clk);
         n++;
         if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (tx_eot === 1'b1) got_eot = 1'b1;
            else rx_q.push_back(tx_data);
         end
      end
      tx_ready <= 1'b0;
   endtask
   // Write sequence, closed by the end mark once all bytes are sent
   task automatic wr_seq(input logic [4:0] la, input logic [7:0] dd, input logic [7:0] b[$]);
      send(`LRS_MSG_LISTEN, {3'h0, la});
      send(`LRS_MSG_DDL, dd);
      foreach (b[i]) send(`LRS_MSG_DATA, b[i]);
      send(`LRS_MSG_EOT_OK, 8'h00);
      send(`LRS_MSG_UNLISTEN, 8'h00);
   endtask
   // Readback start; other listeners are cleared first so only we consume the bytes
   task automatic rd_start(input logic [4:0] la, input logic [7:0] dd);
      send(`LRS_MSG_UNLISTEN, 8'h00);
      send(`LRS_MSG_TALK, {3'h0, la});
      send(`LRS_MSG_DDT, dd);
      send(`LRS_MSG_SEND_DATA, 8'h00);
   endtask
endmodule

// File: test/lrs_seq_sva.sv
// Concurrent checks on the ports of the loop register access sequencer
`include "lrs_regs.svh"
module lrs_seq_sva #(
   parameter int CTRL_COUNT = 14,
   parameter int CHAR_COUNT = 12
) (
   input wire logic REF_CLK_IN,
   input wire logic RSTN_IN,
   input wire logic MSG_VALID_IN,
   input wire logic [3:0] MSG_KIND_IN,
   input wire logic [7:0] MSG_ARG_IN,
   input wire logic TX_VALID_OUT,
   input wire logic TX_EOT_OUT,
   input wire logic [7:0] TX_DATA_OUT,
   input wire logic TX_READY_IN,
   input wire logic [7:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   input wire logic AVS_WAITREQUEST_OUT,
   input wire logic LISTENER_OUT,
   input wire logic TALKER_OUT
);
   logic [4:0] addr_r;
   logic loc_r;
   logic sd_w;
   logic acc_w;
   logic req_w;
   logic own_w;
   // Message, acceptance and bus request decodes used by the checks
   assign sd_w = MSG_VALID_IN && MSG_KIND_IN == `LRS_MSG_SEND_DATA;
   assign acc_w = TX_VALID_OUT && TX_READY_IN;
   assign req_w = AVS_READ_IN || AVS_WRITE_IN;
   assign own_w = MSG_ARG_IN[4:0] == addr_r;
   // Mirror of loop address and mode, so the checks follow software changes
   always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         addr_r <= `LRS_LOOP_ADDR_RST;
         loc_r <= `LRS_LOCAL_RST;
      end else if (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == `LRS_CTRL_OFS) begin
         if (AVS_BYTEENABLE_IN[0]) addr_r <= AVS_WRITEDATA_IN[4:0];
         if (AVS_BYTEENABLE_IN[1]) loc_r <= AVS_WRITEDATA_IN[`LRS_CTRL_LOCAL_BIT];
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   a_listen_enter: assert property (MSG_VALID_IN && MSG_KIND_IN == `LRS_MSG_LISTEN && own_w |=> LISTENER_OUT)
      else $error("listener state not entered");
   a_unlisten_leave: assert property (MSG_VALID_IN && MSG_KIND_IN == `LRS_MSG_UNLISTEN |=> !LISTENER_OUT)
      else $error("listener state kept after unlisten");
   a_talk_enter: assert property (MSG_VALID_IN && MSG_KIND_IN == `LRS_MSG_TALK && own_w |=> TALKER_OUT)
      else $error("talker state not entered");
   a_talk_other: assert property (MSG_VALID_IN && MSG_KIND_IN == `LRS_MSG_TALK && !own_w |=> !TALKER_OUT)
      else $error("talker state kept after foreign talk address");
   a_untalk_stop: assert property (MSG_VALID_IN && MSG_KIND_IN == `LRS_MSG_UNTALK |=> !TALKER_OUT && !TX_VALID_OUT)
      else $error("talker still active after untalk");
   a_offer_hold: assert property (TX_VALID_OUT && !TX_READY_IN && !MSG_VALID_IN && !AVS_WRITE_IN |=>
      TX_VALID_OUT && $stable(TX_DATA_OUT) && $stable(TX_EOT_OUT))
      else $error("offered byte changed before acceptance");
   a_offer_cause: assert property ($rose(TX_VALID_OUT) |-> $past(sd_w, 2) || $past(acc_w, 2) || TX_EOT_OUT)
      else $error("byte offered without send data or acceptance");
   a_eot_empty: assert property (TX_EOT_OUT |-> TX_VALID_OUT && TX_DATA_OUT == 8'h00)
      else $error("end mark offered with data or without valid");
   a_remote_quiet: assert property (sd_w && !loc_r |-> ##2 !TX_VALID_OUT)
      else $error("readback started outside local mode");
   a_wait_first: assert property ($rose(req_w) |-> AVS_WAITREQUEST_OUT)
      else $error("bus request accepted in its first cycle");
endmodule

bind lrs_seq lrs_seq_sva #(.CTRL_COUNT(CTRL_COUNT), .CHAR_COUNT(CHAR_COUNT)) u_sva (
   .REF_CLK_IN(REF_CLK_IN), .RSTN_IN(RSTN_IN), .MSG_VALID_IN(MSG_VALID_IN), .MSG_KIND_IN(MSG_KIND_IN),
   .MSG_ARG_IN(MSG_ARG_IN), .TX_VALID_OUT(TX_VALID_OUT), .TX_EOT_OUT(TX_EOT_OUT), .TX_DATA_OUT(TX_DATA_OUT),
   .TX_READY_IN(TX_READY_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
   .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
   .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .LISTENER_OUT(LISTENER_OUT), .TALKER_OUT(TALKER_OUT));

// File: test/lrs_seq_tb_top.sv
// Self-checking bench: loop register writes, readback and register bus access
`include "lrs_regs.svh"
module lrs_seq_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn, m_valid, tx_ready, tx_valid, tx_eot, avs_rd, avs_wr, avs_wait, lis, tlk;
   logic [3:0] m_kind;
   logic [3:0] avs_be;
   logic [7:0] m_arg, tx_data, avs_addr;
   logic [31:0] avs_wd, avs_rdata, rd;
   logic [4:0] la;
   logic [3:0] cr[14];
   logic [7:0] cb[12];
   logic [7:0] q[$];
   int fails, checks;
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   lrs_seq #(.CTRL_COUNT(14), .CHAR_COUNT(12)) dut (.REF_CLK_IN(clk), .RSTN_IN(rstn), .MSG_VALID_IN(m_valid),
      .MSG_KIND_IN(m_kind), .MSG_ARG_IN(m_arg), .TX_VALID_OUT(tx_valid), .TX_EOT_OUT(tx_eot),
      .TX_DATA_OUT(tx_data), .TX_READY_IN(tx_ready), .AVS_ADDRESS_IN(avs_addr), .AVS_READ_IN(avs_rd),
      .AVS_WRITE_IN(avs_wr), .AVS_WRITEDATA_IN(avs_wd), .AVS_BYTEENABLE_IN(avs_be),
      .AVS_READDATA_OUT(avs_rdata), .AVS_WAITREQUEST_OUT(avs_wait), .LISTENER_OUT(lis), .TALKER_OUT(tlk));
   lrs_ctl_model ctl (.clk(clk), .msg_valid(m_valid), .msg_kind(m_kind), .msg_arg(m_arg),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_eot(tx_eot), .tx_data(tx_data));
   // ****************************************
   // Bench tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict();
      if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Bus cycle held until waitrequest is seen low; wait is bounded so a stall shows as a fault
   task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] v);
      int n;
      n = 0;
      @(posedge clk);
      avs_addr <= a;
      avs_wd <= d;
      avs_wr <= wr;
      avs_rd <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_wait !== 1'b0 && n < 200);
      v = avs_rdata;
      if (n >= 200) fails++;
      avs_wr <= 1'b0;
      avs_rd <= 1'b0;
      avs_addr <= ~a;
      avs_wd <= ~d;
   endtask
   function automatic logic [7:0] exp_rb(input logic [7:0] dd, input int i);
      return (dd == `LRS_DD_CTRL) ? {`LRS_RB_UPPER, cr[i]} : cb[i];
   endfunction
   task automatic chk_ctrl();
      logic [31:0] v;
      for (int i = 0; i < 14; i++) begin
         av(1'b0, 8'(`LRS_CREG_BASE + 4 * i), 32'h0, v);
         chk("ctrl_reg", v, {28'h0, cr[i]});
      end
   endtask
   task automatic rd_chk(input logic [7:0] dd, input bit slow, input int n);
      ctl.rd_start(la, dd);
      ctl.collect(slow, 20, 600);
      chk("rb_count", 32'(ctl.rx_q.size()), 32'(n));
      chk("rb_eot", {31'h0, ctl.got_eot}, 32'h1);
      foreach (ctl.rx_q[i]) chk("rb_byte", {24'h0, ctl.rx_q[i]}, {24'h0, exp_rb(dd, i)});
      ctl.send(`LRS_MSG_UNTALK, 8'h00);
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      print_verdict();
   end
   // Main sequence: reset values, then each transfer kind with corner cases
   initial begin
      void'($urandom(32'h9ec5fd93));
      rstn = 1'b0;
      avs_rd = 1'b0;
      avs_wr = 1'b0;
      avs_addr = 8'h00;
      avs_wd = 32'h0;
      avs_be = 4'hf;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      av(1'b0, `LRS_CTRL_OFS, 32'h0, rd);
      chk("ctrl_rst", rd, 32'h00000100);
      av(1'b0, 8'h5c, 32'h0, rd);
      chk("rate_rst", rd, 32'h0000000e);
      av(1'b0, 8'h20, 32'h0, rd);
      chk("unmapped", rd, 32'h0);
      la = 5'($urandom_range(1, 31));
      av(1'b1, `LRS_CTRL_OFS, {23'h0, 1'b1, 3'h0, la}, rd);
      // Full control write plus one surplus byte that must be dropped
      q = {};
      foreach (cr[i]) begin
         cr[i] = 4'($urandom);
         q.push_back({4'h0, cr[i]});
      end
      q.push_back(8'h05);
      ctl.wr_seq(la, `LRS_DD_CTRL, q);
      chk_ctrl();
      rd_chk(`LRS_DD_CTRL, 1'b1, 14);
      // Character bank carries whole bytes
      q = {};
      foreach (cb[i]) begin
         cb[i] = 8'($urandom);
         q.push_back(cb[i]);
      end
      ctl.wr_seq(la, `LRS_DD_CHAR, q);
      rd_chk(`LRS_DD_CHAR, 1'b0, 12);
      // A fresh selection restarts at the first register
      cr[0] = 4'($urandom);
      cr[1] = 4'($urandom);
      q = '{{4'h0, cr[0]}, {4'h0, cr[1]}};
      ctl.wr_seq(la, `LRS_DD_CTRL, q);
      chk_ctrl();
      // Outside local mode device messages change nothing
      av(1'b1, `LRS_CTRL_OFS, {27'h0, la}, rd);
      q = '{8'h0a, 8'h0b, 8'h0c};
      ctl.wr_seq(la, `LRS_DD_CTRL, q);
      ctl.rd_start(la, `LRS_DD_CTRL);
      ctl.collect(1'b0, 20, 40);
      chk("remote_rb", 32'(ctl.rx_q.size()) + 32'(ctl.got_eot), 32'h0);
      ctl.send(`LRS_MSG_UNTALK, 8'h00);
      av(1'b1, `LRS_CTRL_OFS, {23'h0, 1'b1, 3'h0, la}, rd);
      chk_ctrl();
      // Untalk in mid readback stops the bytes
      ctl.rd_start(la, `LRS_DD_CTRL);
      ctl.collect(1'b0, 3, 200);
      ctl.send(`LRS_MSG_UNTALK, 8'h00);
      @(negedge clk);
      chk("untalk", {31'h0, tlk}, 32'h0);
      ctl.collect(1'b0, 20, 30);
      chk("after_untalk", 32'(ctl.rx_q.size()), 32'h0);
      // Another device's talk address removes us as talker
      ctl.send(`LRS_MSG_TALK, {3'h0, la});
      @(negedge clk);
      chk("talk_own", {31'h0, tlk}, 32'h1);
      ctl.send(`LRS_MSG_TALK, {3'h0, la ^ 5'h01});
      @(negedge clk);
      chk("talk_other", {31'h0, tlk}, 32'h0);
      // Untalk while End-OK is offered withdraws the mark as well
      ctl.rd_start(la, `LRS_DD_CTRL);
      ctl.collect(1'b0, 14, 200);
      ctl.send(`LRS_MSG_UNTALK, 8'h00);
      @(negedge clk);
      chk("untalk_eot", {30'h0, tx_valid, tx_eot}, 32'h0);
      // Listener state follows only its own listen address, and unlisten
      ctl.send(`LRS_MSG_LISTEN, {3'h0, la ^ 5'h01});
      @(negedge clk);
      chk("listen_other", {31'h0, lis}, 32'h0);
      ctl.send(`LRS_MSG_LISTEN, {3'h0, la});
      av(1'b0, `LRS_STAT_OFS, 32'h0, rd);
      chk("listen_own", {31'h0, lis}, 32'h1);
      chk("stat_listen", {31'h0, rd[`LRS_STAT_LISTEN_BIT]}, 32'h1);
      ctl.send(`LRS_MSG_UNLISTEN, 8'h00);
      @(negedge clk);
      chk("unlisten", {31'h0, lis}, 32'h0);
      // Byte 1 disabled: the local bit must survive a write that clears it
      avs_be <= 4'h1;
      av(1'b1, `LRS_CTRL_OFS, {27'h0, la}, rd);
      avs_be <= 4'hf;
      av(1'b0, `LRS_CTRL_OFS, 32'h0, rd);
      chk("ctrl_be", rd, {23'h0, 1'b1, 3'h0, la});
      print_verdict();
   end
endmodule
